//--- load_switch_controller.sv
`timescale 1ns/1ps
module load_switch_controller
  import load_switch_pkg::*;
(
  input  wire logic        mclk,           // System clock, 200 MHz.
  input  wire logic        rst,            // Synchronous reset, active high.
  input  wire logic        minuteTick,     // One-cycle pulse each minute.
  input  wire logic        dayTick,        // One-cycle pulse at day start.
  input  wire logic [19:0] genPower,       // Measured generated power in watts.
  input  wire logic [19:0] homePower,      // Measured building consumption in watts.
  input  wire logic        converterOn,    // Converter is feeding.
  input  wire logic        faultActive,    // Converter fault present.
  input  wire logic [1:0]  ripplePins,     // Ripple receiver contacts.
  output logic             loadSwitchOutput,// Load relay drive.
  output logic      [6:0]  limitPct,       // Feed-in power limit percent.
  input  wire logic        s_axi_aclk_unused, // Not used; tie low.
  input  wire logic [7:0]  s_axi_awaddr,   // Write address.
  input  wire logic        s_axi_awvalid,  // Write address valid.
  output logic             s_axi_awready,  // Write address ready.
  input  wire logic [31:0] s_axi_wdata,    // Write data.
  input  wire logic [3:0]  s_axi_wstrb,    // Write strobes.
  input  wire logic        s_axi_wvalid,   // Write data valid.
  output logic             s_axi_wready,   // Write data ready.
  output logic      [1:0]  s_axi_bresp,    // Write response.
  output logic             s_axi_bvalid,   // Write response valid.
  input  wire logic        s_axi_bready,   // Write response ready.
  input  wire logic [7:0]  s_axi_araddr,   // Read address.
  input  wire logic        s_axi_arvalid,  // Read address valid.
  output logic             s_axi_arready,  // Read address ready.
  output logic      [31:0] s_axi_rdata,    // Read data.
  output logic      [1:0]  s_axi_rresp,    // Read response.
  output logic             s_axi_rvalid,   // Read response valid.
  input  wire logic        s_axi_rready    // Read response ready.
);

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Register file.
  logic [5:0]  ctrlReg;
  logic [19:0] onPowerReg;
  logic [19:0] offPowerReg;
  logic [10:0] qualReg;
  logic [10:0] runReg;
  logic [7:0]  actLimitReg;

  // AXI write and read paths.
  logic        awHeldReg;
  logic [7:0]  awAddrReg;
  logic        wHeldReg;
  logic [31:0] wDataReg;
  logic [3:0]  wStrbReg;
  logic        bValidReg;
  logic [1:0]  bRespReg;
  logic        rValidReg;
  logic [31:0] rDataReg;
  logic [1:0]  rRespReg;

  wire logic awTake  = s_axi_awvalid && !awHeldReg && !bValidReg;
  wire logic wTake   = s_axi_wvalid && !wHeldReg && !bValidReg;
  wire logic doWrite = awHeldReg && wHeldReg && !bValidReg;
  wire logic arTake  = s_axi_arvalid && !rValidReg;
  wire logic wFull   = (wStrbReg == 4'hf);

  wire logic wrCtrl  = doWrite && (awAddrReg == ADDR_CTRL);
  wire logic wrOn    = doWrite && (awAddrReg == ADDR_ON_POWER);
  wire logic wrOff   = doWrite && (awAddrReg == ADDR_OFF_POWER);
  wire logic wrQual  = doWrite && (awAddrReg == ADDR_QUAL_TIME);
  wire logic wrRun   = doWrite && (awAddrReg == ADDR_RUN_TIME);
  wire logic wrAct   = doWrite && (awAddrReg == ADDR_ACT_LIMIT);
  wire logic wrHit   = wrCtrl || wrOn || wrOff || wrQual || wrRun || wrAct;

  // Out-of-range values are refused so the counters always see a legal setting.
  wire logic onOk    = (wDataReg[19:0] >= 20'h00001) && (wDataReg[19:0] <= POWER_MAX)
                       && (wDataReg[31:20] == 12'h000);
  wire logic offOk   = (wDataReg[19:0] <= POWER_MAX) && (wDataReg[31:20] == 12'h000);
  wire logic qualOk  = (wDataReg[10:0] >= 11'h001) && (wDataReg[10:0] <= QUAL_MAX)
                       && (wDataReg[31:11] == 21'h0);
  wire logic runOk   = (wDataReg[10:0] >= 11'h001) && (wDataReg[10:0] <= RUN_MAX)
                       && (wDataReg[31:11] == 21'h0);
  wire logic valueOk = wFull && (wrCtrl || wrAct || (wrOn && onOk) || (wrOff && offOk)
                       || (wrQual && qualOk) || (wrRun && runOk));

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      awHeldReg <= 1'b0;
      awAddrReg <= 8'h00;
      wHeldReg  <= 1'b0;
      wDataReg  <= 32'h0;
      wStrbReg  <= 4'h0;
      bValidReg <= 1'b0;
      bRespReg  <= RESP_OKAY;
    end
    else
    begin
      if (awTake)
      begin
        awHeldReg <= 1'b1;
        awAddrReg <= s_axi_awaddr;
      end
      if (wTake)
      begin
        wHeldReg <= 1'b1;
        wDataReg <= s_axi_wdata;
        wStrbReg <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awHeldReg <= 1'b0;
        wHeldReg  <= 1'b0;
        bValidReg <= 1'b1;
        bRespReg  <= (wrHit && valueOk) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bValidReg && s_axi_bready)
        bValidReg <= 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ctrlReg     <= CTRL_RESET;
      onPowerReg  <= ON_POWER_RESET;
      offPowerReg <= OFF_POWER_RESET;
      qualReg     <= QUAL_RESET;
      runReg      <= RUN_RESET;
      actLimitReg <= ACT_RESET;
    end
    else if (valueOk)
    begin
      if (wrCtrl)
        ctrlReg <= wDataReg[5:0];
      if (wrOn)
        onPowerReg <= wDataReg[19:0];
      if (wrOff)
        offPowerReg <= wDataReg[19:0];
      if (wrQual)
        qualReg <= wDataReg[10:0];
      if (wrRun)
        runReg <= wDataReg[10:0];
      if (wrAct)
        actLimitReg <= wDataReg[7:0];
    end
  end

  // Controller state, declared ahead of the read mux that reports it.
  sw_state_t   stateReg;
  sw_state_t   stateNext;
  logic [10:0] minCntReg;
  logic [7:0]  noGenReg;
  logic [7:0]  actCntReg;
  logic        abandonedReg;

  logic [31:0] rdMux;
  logic        rdHit;
  always_comb
  begin
    rdMux = 32'h0;
    rdHit = 1'b1;
    unique case (s_axi_araddr)
      ADDR_CTRL:      rdMux = {26'h0, ctrlReg};
      ADDR_ON_POWER:  rdMux = {12'h0, onPowerReg};
      ADDR_OFF_POWER: rdMux = {12'h0, offPowerReg};
      ADDR_QUAL_TIME: rdMux = {21'h0, qualReg};
      ADDR_RUN_TIME:  rdMux = {21'h0, runReg};
      ADDR_ACT_LIMIT: rdMux = {24'h0, actLimitReg};
      ADDR_STATUS:    rdMux = {9'h0, abandonedReg, actCntReg, minCntReg,
                               stateReg, loadSwitchOutput};
      ADDR_LIMIT_PCT: rdMux = {25'h0, limitPct};
      default:        rdHit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rValidReg <= 1'b0;
      rDataReg  <= 32'h0;
      rRespReg  <= RESP_OKAY;
    end
    else if (arTake)
    begin
      rValidReg <= 1'b1;
      rDataReg  <= rdMux;
      rRespReg  <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rValidReg && s_axi_rready)
      rValidReg <= 1'b0;
  end

  assign s_axi_awready = !awHeldReg && !bValidReg;
  assign s_axi_wready  = !wHeldReg && !bValidReg;
  assign s_axi_bvalid  = bValidReg;
  assign s_axi_bresp   = bRespReg;
  assign s_axi_arready = !rValidReg;
  assign s_axi_rvalid  = rValidReg;
  assign s_axi_rdata   = rDataReg;
  assign s_axi_rresp   = rRespReg;

  // Configuration view and power comparisons.
  wire logic        enable    = ctrlReg[CTRL_ENABLE_BIT];
  wire logic        powerMode = ctrlReg[CTRL_MODE_BIT];
  wire logic        dynamic   = ctrlReg[CTRL_DYNAMIC_BIT];
  wire logic        delayEn   = ctrlReg[CTRL_DELAY_BIT];
  wire logic [20:0] onLimit   = dynamic ? (21'(onPowerReg) + 21'(homePower))
                                        : 21'(onPowerReg);
  wire logic [20:0] offLimit  = dynamic ? (21'(offPowerReg) + 21'(homePower))
                                        : 21'(offPowerReg);
  wire logic        aboveOn   = (21'(genPower) > onLimit);
  wire logic        reachOn   = (21'(genPower) >= onLimit);
  wire logic        belowOff  = (21'(genPower) < offLimit);
  wire logic        dropout   = !converterOn || faultActive;
  wire logic        noCurrent = (genPower == 20'h0);
  wire logic        actsLeft  = (actCntReg < actLimitReg);
  wire logic        qualDone  = minuteTick && (minCntReg + 11'h001 >= qualReg);
  wire logic        runDone   = minuteTick && (minCntReg + 11'h001 >= runReg);
  wire logic        holdDone  = minuteTick && (minCntReg + 11'h001 >= qualReg);
  wire logic        stopCause = powerMode ? (belowOff || dropout)
                                          : (runDone || dropout);
  wire logic        noGenDone = minuteTick && (noGenReg + 8'h01 >= NO_GEN_MINUTES);

  always_comb
  begin
    stateNext = stateReg;
    unique case (stateReg)
      ST_IDLE:
        if (enable && !dropout && !abandonedReg)
        begin
          if (powerMode && reachOn)
            stateNext = ST_RUN;
          else if (!powerMode && actsLeft && aboveOn)
            stateNext = ST_QUALIFY;
        end
      ST_QUALIFY:
        if (!enable || powerMode || dropout || !aboveOn)
          stateNext = ST_IDLE;
        else if (qualDone)
          stateNext = ST_RUN;
      ST_RUN:
        if (!enable)
          stateNext = ST_IDLE;
        else if (!powerMode && runDone)
          stateNext = ST_IDLE;
        else if (stopCause)
          stateNext = delayEn ? ST_HOLD : ST_IDLE;
      ST_HOLD:
        if (!enable)
          stateNext = ST_IDLE;
        else if (!dropout && !(powerMode && belowOff))
          stateNext = ST_RUN;
        else if (holdDone)
          stateNext = ST_IDLE;
    endcase
  end

  // The minute counter serves whichever timer the state needs.
  wire logic stateChange = (stateNext != stateReg);
  wire logic runStart    = (stateReg == ST_QUALIFY) && (stateNext == ST_RUN);

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      stateReg     <= ST_IDLE;
      minCntReg    <= 11'h000;
      noGenReg     <= 8'h00;
      actCntReg    <= 8'h00;
      abandonedReg <= 1'b0;
    end
    else
    begin
      stateReg <= stateNext;
      if (stateChange && !(stateReg == ST_HOLD && stateNext == ST_RUN))
        minCntReg <= 11'h000;
      else if (minuteTick && stateReg != ST_IDLE && !powerMode)
        minCntReg <= minCntReg + 11'h001;
      else if (minuteTick && stateReg == ST_HOLD)
        minCntReg <= minCntReg + 11'h001;
      if (!noCurrent || stateReg == ST_IDLE)
        noGenReg <= 8'h00;
      else if (minuteTick)
        noGenReg <= noGenReg + 8'h01;
      // A run that starts on the day edge still counts against the new day.
      if (dayTick)
        actCntReg <= runStart ? 8'h01 : 8'h00;
      else if (runStart)
        actCntReg <= actCntReg + 8'h01;
      if (!powerMode && stateReg != ST_IDLE && noGenDone)
        abandonedReg <= 1'b1;
      else if (dayTick)
        abandonedReg <= 1'b0;
      if (!powerMode && noGenDone && stateReg != ST_IDLE)
        stateReg <= ST_IDLE;
    end
  end

  assign loadSwitchOutput = (stateReg == ST_RUN) || (stateReg == ST_HOLD);

  ripple_level_select u_ripple
  (
    .mclk         (mclk),
    .rst          (rst),
    .ripplePins   (ripplePins),
    .rippleActive (ctrlReg[CTRL_RIPPLE_BIT]),
    .isMaster     (ctrlReg[CTRL_MASTER_BIT]),
    .limitPct     (limitPct)
  );

  property p_off_after_reset;
    @(posedge mclk) rst |=> !loadSwitchOutput;
  endproperty
  a_off_after_reset: assert property (p_off_after_reset)
    else $error("Output on right after reset.");

  property p_qualify_drop;
    @(posedge mclk) disable iff (rst)
      (stateReg == ST_QUALIFY && !aboveOn) |=> (stateReg == ST_IDLE);
  endproperty
  a_qualify_drop: assert property (p_qualify_drop)
    else $error("Qualify timer not restarted on power drop.");

  property p_power_on;
    @(posedge mclk) disable iff (rst)
      (stateReg == ST_IDLE && enable && powerMode && reachOn && !dropout
       && !abandonedReg) |=> loadSwitchOutput;
  endproperty
  a_power_on: assert property (p_power_on)
    else $error("Power mode did not switch on.");

  property p_power_off;
    @(posedge mclk) disable iff (rst)
      (stateReg == ST_RUN && enable && powerMode && belowOff && !delayEn)
      |=> !loadSwitchOutput;
  endproperty
  a_power_off: assert property (p_power_off)
    else $error("Power mode did not switch off.");

  property p_hold_keeps_on;
    @(posedge mclk) disable iff (rst)
      (stateReg == ST_RUN && enable && delayEn && dropout
       && !(!powerMode && (runDone || noGenDone))) |=> loadSwitchOutput;
  endproperty
  a_hold_keeps_on: assert property (p_hold_keeps_on)
    else $error("Off-delay did not hold the output.");

  property p_shutdown_ends;
    @(posedge mclk) disable iff (rst)
      (stateReg == ST_RUN && !powerMode && dropout && !delayEn) |=> !loadSwitchOutput;
  endproperty
  a_shutdown_ends: assert property (p_shutdown_ends)
    else $error("Shutdown did not end run time.");

  property p_act_limit;
    @(posedge mclk) disable iff (rst)
      (stateReg == ST_IDLE && !powerMode && !actsLeft) |=> (stateReg != ST_QUALIFY);
  endproperty
  a_act_limit: assert property (p_act_limit)
    else $error("Activation count exceeded.");

  property p_day_clear;
    @(posedge mclk) disable iff (rst) (dayTick && !runStart) |=> (actCntReg == 8'h00);
  endproperty
  a_day_clear: assert property (p_day_clear)
    else $error("Daily counter not cleared.");

  property p_bresp_order;
    @(posedge mclk) disable iff (rst) doWrite |=> s_axi_bvalid;
  endproperty
  a_bresp_order: assert property (p_bresp_order)
    else $error("Write response missing.");

  c_timed_run: cover property (@(posedge mclk) disable iff (rst) runStart);
  c_hold: cover property (@(posedge mclk) disable iff (rst)
    stateReg == ST_HOLD ##1 stateReg == ST_RUN);
  c_abandon: cover property (@(posedge mclk) disable iff (rst) $rose(abandonedReg));

endmodule : load_switch_controller

//--- load_switch_pkg.sv
package load_switch_pkg;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_ON_POWER   = 8'h04;
  localparam logic [7:0] ADDR_OFF_POWER  = 8'h08;
  localparam logic [7:0] ADDR_QUAL_TIME  = 8'h0c;
  localparam logic [7:0] ADDR_RUN_TIME   = 8'h10;
  localparam logic [7:0] ADDR_ACT_LIMIT  = 8'h14;
  localparam logic [7:0] ADDR_STATUS     = 8'h18;
  localparam logic [7:0] ADDR_LIMIT_PCT  = 8'h1c;

  // Control register field positions.
  localparam int CTRL_ENABLE_BIT  = 0;
  localparam int CTRL_MODE_BIT    = 1;
  localparam int CTRL_DYNAMIC_BIT = 2;
  localparam int CTRL_DELAY_BIT   = 3;
  localparam int CTRL_RIPPLE_BIT  = 4;
  localparam int CTRL_MASTER_BIT  = 5;

  // Reset values.
  localparam logic [5:0]  CTRL_RESET      = 6'h00;
  localparam logic [19:0] ON_POWER_RESET  = 20'h003e8;
  localparam logic [19:0] OFF_POWER_RESET = 20'h001f4;
  localparam logic [10:0] QUAL_RESET      = 11'h001;
  localparam logic [10:0] RUN_RESET       = 11'h001;
  localparam logic [7:0]  ACT_RESET       = 8'h01;

  // Programmable ranges.
  localparam logic [19:0] POWER_MAX = 20'hf3e58;
  localparam logic [10:0] QUAL_MAX  = 11'h2d0;
  localparam logic [10:0] RUN_MAX   = 11'h5a0;
  localparam int          NO_GEN_HOURS = 3;
  localparam logic [7:0]  NO_GEN_MINUTES = 8'(NO_GEN_HOURS * 60);

  // Ripple receiver level codes and percentages.
  localparam logic [6:0] PCT_FULL  = 7'h64;
  localparam logic [6:0] PCT_SIXTY = 7'h3c;
  localparam logic [6:0] PCT_THIRTY = 7'h1e;
  localparam logic [6:0] PCT_ZERO  = 7'h00;

  typedef enum logic [1:0]
  {
    ST_IDLE    = 2'b00,
    ST_QUALIFY = 2'b01,
    ST_RUN     = 2'b11,
    ST_HOLD    = 2'b10
  } sw_state_t;

  typedef struct packed
  {
    logic        enable;
    logic        powerMode;
    logic        dynamic;
    logic        delayEn;
    logic [19:0] onPower;
    logic [19:0] offPower;
    logic [10:0] qualTime;
    logic [10:0] runTime;
    logic [7:0]  actLimit;
  } sw_cfg_t;

endpackage : load_switch_pkg

//--- ripple_level_select.sv
`timescale 1ns/1ps
module ripple_level_select
  import load_switch_pkg::*;
(
  input  wire logic       mclk,        // System clock.
  input  wire logic       rst,         // Synchronous reset.
  input  wire logic [1:0] ripplePins,  // Receiver contacts from the pins.
  input  wire logic       rippleActive,// Analogue input set to power control.
  input  wire logic       isMaster,    // This unit holds the receiver.
  output logic      [6:0] limitPct     // Feed-in power limit in percent.
);

  logic [1:0] s1Reg;
  logic [1:0] s2Reg;
  logic [1:0] s3Reg;
  logic [1:0] stableReg;
  logic [6:0] pctReg;
  logic [6:0] pctNext;

  wire logic agree = (s2Reg == s3Reg);

  // Only the master obeys the receiver; without acceptance the unit feeds fully.
  always_comb
  begin
    pctNext = PCT_FULL;
    if (rippleActive && isMaster)
    begin
      unique case (stableReg)
        2'b00: pctNext = PCT_FULL;
        2'b01: pctNext = PCT_SIXTY;
        2'b10: pctNext = PCT_THIRTY;
        2'b11: pctNext = PCT_ZERO;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s1Reg     <= 2'h0;
      s2Reg     <= 2'h0;
      s3Reg     <= 2'h0;
      stableReg <= 2'h0;
      pctReg    <= PCT_FULL;
    end
    else
    begin
      s1Reg <= ripplePins;
      s2Reg <= s1Reg;
      s3Reg <= s2Reg;
      if (agree)
        stableReg <= s3Reg;
      pctReg <= pctNext;
    end
  end

  assign limitPct = pctReg;

  property p_limit_full_inactive;
    @(posedge mclk) disable iff (rst)
      !(rippleActive && isMaster) |=> (limitPct == PCT_FULL);
  endproperty
  a_limit_full_inactive: assert property (p_limit_full_inactive)
    else $error("Limit not full while receiver control inactive.");

  property p_limit_levels;
    @(posedge mclk) disable iff (rst)
      (limitPct == PCT_FULL) || (limitPct == PCT_SIXTY) ||
      (limitPct == PCT_THIRTY) || (limitPct == PCT_ZERO);
  endproperty
  a_limit_levels: assert property (p_limit_levels)
    else $error("Limit outside the four levels.");

endmodule : ripple_level_select

//--- ripple_relay_model.sv
`timescale 1ns/1ps
module ripple_relay_model
#(
  parameter int PICKUP = 2  // Relay pickup time in clocks.
)
(
  input  wire logic       mclk,        // System clock.
  input  wire logic [1:0] level,       // Level commanded by the utility.
  input  wire logic       drive,       // Relay coil drive.
  output logic      [1:0] ripplePins,  // Receiver contacts.
  output logic            relayOn      // Relay contact closed.
);
  int cnt = 0;

  // The receiver holds its contact code steadily between commands.
  assign ripplePins = level;

  // A real relay needs time to pick up, so a short drive pulse never closes it.
  always @(posedge mclk)
  begin
    cnt <= drive ? ((cnt < PICKUP) ? cnt + 1 : cnt) : 0;
  end

  assign relayOn = (cnt == PICKUP);
endmodule : ripple_relay_model

//--- load_switch_controller_test.sv
`timescale 1ns/1ps
module load_switch_controller_test;
  import load_switch_pkg::*;
  logic        mclk = 0, rst = 1, minuteTick = 0, dayTick = 0;
  logic        converterOn = 1, faultActive = 0, loadSwitchOutput, relayOn, st;
  logic [19:0] genPower = '0, homePower = '0;
  logic [1:0]  ripplePins, level = 2'h0, bresp, rresp;
  logic [6:0]  limitPct;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, onP, offP, g, h;
  logic [3:0]  strb = 4'hf;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  int          num_errors = 0, num_checks = 0, cycles = 0;
  logic [7:0]  ra [8] = '{ADDR_CTRL, ADDR_ON_POWER, ADDR_OFF_POWER, ADDR_QUAL_TIME,
                          ADDR_RUN_TIME, ADDR_ACT_LIMIT, ADDR_STATUS, ADDR_LIMIT_PCT};
  logic [31:0] rv [8] = '{32'(CTRL_RESET), 32'(ON_POWER_RESET), 32'(OFF_POWER_RESET),
                          32'(QUAL_RESET), 32'(RUN_RESET), 32'(ACT_RESET), 32'h0,
                          32'(PCT_FULL)};
  logic [7:0]  wa [7] = '{ADDR_QUAL_TIME, ADDR_QUAL_TIME, ADDR_QUAL_TIME, ADDR_RUN_TIME,
                          ADDR_RUN_TIME, ADDR_ON_POWER, ADDR_ON_POWER};
  logic [31:0] wd [7] = '{32'h2d1, 32'h2d0, 32'h0, 32'h5a1, 32'h5a0, 32'hf3e59, 32'hf3e58};
  logic [1:0]  we [7] = '{2'h2, 2'h0, 2'h2, 2'h2, 2'h0, 2'h2, 2'h0};

  load_switch_controller uut
  (
    .mclk, .rst, .minuteTick, .dayTick, .genPower, .homePower, .converterOn, .faultActive,
    .ripplePins, .loadSwitchOutput, .limitPct, .s_axi_aclk_unused(1'b0),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  ripple_relay_model far
  (
    .mclk, .level, .drive(loadSwitchOutput), .ripplePins, .relayOn
  );

  initial forever #2.5 mclk = ~mclk;

  task report_and_stop;
    if (num_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      num_errors++;
      report_and_stop();
    end
  end

  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task tk(input int n);
    repeat (n)
    begin
      minuteTick <= 1'b1;
      cyc(1);
      minuteTick <= 1'b0;
      cyc(3);
    end
  endtask : tk

  task day;
    dayTick <= 1'b1;
    cyc(1);
    dayTick <= 1'b0;
    cyc(1);
  endtask : day

  // Address and data are offered together and each is released at its own handshake.
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1;
    w = 1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw || w)
    begin
      cyc(1);
      if (aw && awready === 1'b1)
      begin
        awvalid <= 1'b0;
        aw = 0;
      end
      if (w && wready === 1'b1)
      begin
        wvalid <= 1'b0;
        w = 0;
      end
    end
    while (bvalid !== 1'b1) cyc(1);
    bready <= 1'b0;
    chk(bresp, er);
    cyc(1);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do cyc(1); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) cyc(1);
    rready <= 1'b0;
    chk(rdata, ed);
    chk(rresp, er);
    cyc(1);
  endtask : rd

  function automatic logic [6:0] pct(input logic [1:0] c);
    return (c == 2'h0) ? PCT_FULL : (c == 2'h1) ? PCT_SIXTY :
           (c == 2'h2) ? PCT_THIRTY : PCT_ZERO;
  endfunction : pct

  function automatic logic hyst(input logic s, input logic [31:0] p, on, off);
    return (p >= on) ? 1'b1 : ((p < off) ? 1'b0 : s);
  endfunction : hyst

  initial
  begin
    void'($urandom(32'ha374));
    cyc(10);
    rst <= 1'b0;
    cyc(1);
    chk(loadSwitchOutput, 0);
    for (int i = 0; i < 8; i++) rd(ra[i], rv[i], 2'h0);
    for (int i = 0; i < 7; i++) wr(wa[i], wd[i], we[i]);
    wr(8'h20, 32'h1, 2'h2);
    rd(8'h20, 32'h0, 2'h2);
    strb <= 4'h3;
    wr(ADDR_ON_POWER, 32'h100, 2'h2);
    strb <= 4'hf;
    rd(ADDR_ON_POWER, 32'hf3e58, 2'h0);
    wr(ADDR_CTRL, 32'h30, 2'h0);
    for (int i = 0; i < 4; i++)
    begin
      level <= 2'(i);
      cyc(8);
      chk(limitPct, pct(2'(i)));
    end
    wr(ADDR_CTRL, 32'h20, 2'h0);
    cyc(4);
    chk(limitPct, 7'h64);
    wr(ADDR_CTRL, 32'h10, 2'h0);
    cyc(4);
    chk(limitPct, 7'h64);
    onP = 32'h3e8 + ($urandom % 32'h61a80);
    offP = onP >> 1;
    wr(ADDR_ON_POWER, onP, 2'h0);
    wr(ADDR_OFF_POWER, offP, 2'h0);
    wr(ADDR_CTRL, 32'h3, 2'h0);
    st = 0;
    for (int i = 0; i < 12; i++)
    begin
      g = (i == 0) ? onP - 1 : (i == 1) ? onP : (i == 2) ? offP : (i == 3) ? offP - 1 :
          $urandom % (onP * 2);
      genPower <= g[19:0];
      cyc(4);
      st = hyst(st, g, onP, offP);
      chk(loadSwitchOutput, st);
    end
    genPower <= onP[19:0];
    cyc(6);
    chk(relayOn, 1);
    genPower <= '0;
    h = $urandom % 32'h1000;
    homePower <= h[19:0];
    wr(ADDR_CTRL, 32'h7, 2'h0);
    g = onP + h;
    genPower <= 20'(g - 1);
    cyc(4);
    chk(loadSwitchOutput, 0);
    genPower <= g[19:0];
    cyc(4);
    chk(loadSwitchOutput, 1);
    wr(ADDR_QUAL_TIME, 32'h2, 2'h0);
    wr(ADDR_CTRL, 32'hb, 2'h0);
    cyc(4);
    converterOn <= 1'b0;
    tk(1);
    chk(loadSwitchOutput, 1);
    converterOn <= 1'b1;
    tk(2);
    chk(loadSwitchOutput, 1);
    faultActive <= 1'b1;
    tk(1);
    chk(loadSwitchOutput, 1);
    tk(2);
    chk(loadSwitchOutput, 0);
    faultActive <= 1'b0;
    genPower <= '0;
    wr(ADDR_RUN_TIME, 32'h2, 2'h0);
    wr(ADDR_ACT_LIMIT, 32'h1, 2'h0);
    wr(ADDR_ON_POWER, 32'h3e8, 2'h0);
    wr(ADDR_CTRL, 32'h1, 2'h0);
    genPower <= 20'h007d0;
    tk(1);
    genPower <= 20'h003e8;
    cyc(2);
    genPower <= 20'h007d0;
    tk(1);
    chk(loadSwitchOutput, 0);
    tk(1);
    chk(loadSwitchOutput, 0);
    tk(1);
    chk(loadSwitchOutput, 1);
    tk(1);
    chk(loadSwitchOutput, 1);
    tk(1);
    chk(loadSwitchOutput, 0);
    tk(3);
    chk(loadSwitchOutput, 0);
    day();
    tk(2);
    chk(loadSwitchOutput, 1);
    converterOn <= 1'b0;
    cyc(3);
    chk(loadSwitchOutput, 0);
    converterOn <= 1'b1;
    wr(ADDR_RUN_TIME, 32'h5a0, 2'h0);
    wr(ADDR_ACT_LIMIT, 32'h3, 2'h0);
    day();
    tk(2);
    chk(loadSwitchOutput, 1);
    genPower <= '0;
    tk(179);
    chk(loadSwitchOutput, 1);
    tk(2);
    chk(loadSwitchOutput, 0);
    genPower <= 20'h007d0;
    tk(3);
    chk(loadSwitchOutput, 0);
    report_and_stop();
  end
endmodule : load_switch_controller_test
